/* cpar_top.sv */
// Parallel configuration port: abort, status word, resync and persist control
//
// Summary of operation
// R1: A direction change while selected aborts configuration or readback.
// R2: Configuration abort drives status on bits 7..4 for four clocks, rest high.
// R3: Host raises direction to read while selected; busy then goes high.
// R4: Status word is driven only while direction stays at read.
// R5: Configuration abort lasts exactly four clocks; status updated by its end.
// R6: Host drives direction to write while selected; busy then goes high.
// R7: Readback abort holds until chip select is released.
// R8: Readback abort drives no status; data pins stay inputs.
// R9: Bit 7 is the error flag, low when an error occurred.
// R10: Bit 6 is high once the sync word was received.
// R11: Bit 5 is high while a readback is in progress.
// R12: Bit 4 is low while an abort is in progress; the code drives it low only on the middle two of the four abort cycles.
// R13: Bits 3..0 read as ones in the status word.
// R14: Status word is not bit reversed like data bytes.
// R15: Alignment and abort bits update each abort cycle.
// R16: After the abort the port is unaligned; sync word realigns it.
// R17: Host deselects then reselects before sending more words.
// R18: Host resends the interrupted packet or restarts from the beginning.
// R19: A low program pulse at any time fully resets the logic; an error set or readback start in the same cycle still sets its flag.
// R20: Without persist, the port is released to user I/O after configuration.
// R21: Select and direction sampled each rising clock; flip found against last sample.
`timescale 1ns/1ps

module cpar_top #(
  // Arbitrary alignment pattern, four bytes
  parameter logic [31:0] SYNC_WORD = 32'hA5C3_5AC3
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Configuration port pins
  input  wire logic       config_clock,
  input  wire logic       chip_sel_n,
  input  wire logic       read_write_dir_n,
  input  wire logic       program_n,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            busy,
  // Configuration core inputs
  input  wire logic       config_error_set,
  input  wire logic       readback_start,
  input  wire logic       readback_done,
  input  wire logic [7:0] readback_data,
  input  wire logic       config_done,
  input  wire logic       persist_en,
  // Configuration core outputs
  output logic      [7:0] config_byte,
  output logic            config_byte_valid,
  output logic            sync_aligned,
  output logic            readback_active,
  output logic            config_error_n,
  output logic            abort_active,
  output logic            user_io_mode,
  output logic            config_reset
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [11:0] pins_async;
  logic [11:0] pins_sync;

  assign pins_async = {config_clock, chip_sel_n, read_write_dir_n,
                       program_n, data_in};

  cpar_sync #(
    .WIDTH     (cpar_pkg::PIN_W),
    .RESET_VAL (cpar_pkg::PIN_RESET)
  ) u_pin_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  wire       config_clock_s   = pins_sync[cpar_pkg::PIN_CONFIG_CLOCK];
  wire       cs_n_s   = pins_sync[cpar_pkg::PIN_CS_N];
  wire       dir_n_s  = pins_sync[cpar_pkg::PIN_DIR_N];
  wire       prog_n_s = pins_sync[cpar_pkg::PIN_PROG_N];
  wire [7:0] din_s    = pins_sync[7:0];

  // ----------------------------------------------------------------
  // Clock edge detection and pin sampling
  // ----------------------------------------------------------------
  logic config_clock_prev_reg;
  logic sel_prev_reg;
  logic sel_prev_next;
  logic dir_prev_reg;
  logic dir_prev_next;

  wire config_clock_rise  = config_clock_s & ~config_clock_prev_reg;
  wire selected   = ~cs_n_s;
  wire dir_read   = dir_n_s;
  wire prog_reset = ~prog_n_s;

  // Direction flip against the previous rising-edge sample
  wire dir_flip = config_clock_rise & selected & sel_prev_reg
                & (dir_n_s != dir_prev_reg);  // [R1] [R21]

  assign sel_prev_next = config_clock_rise ? selected : sel_prev_reg;  // [R21]
  assign dir_prev_next = config_clock_rise ? dir_n_s : dir_prev_reg;   // [R21]

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      config_clock_prev_reg <= 1'b0;
      sel_prev_reg  <= 1'b0;
      dir_prev_reg  <= 1'b0;
    end else begin
      config_clock_prev_reg <= config_clock_s;
      sel_prev_reg  <= sel_prev_next;
      dir_prev_reg  <= dir_prev_next;
    end
  end

  // ----------------------------------------------------------------
  // Bit reversal of data bytes
  // ----------------------------------------------------------------
  logic [7:0] din_swap;
  logic [7:0] rb_swap;

  for (genvar i = 0; i < cpar_pkg::BYTE_W; i++) begin : g_swap
    assign din_swap[i] = din_s[cpar_pkg::BYTE_W-1-i];
    assign rb_swap[i]  = readback_data[cpar_pkg::BYTE_W-1-i];
  end

  // ----------------------------------------------------------------
  // Port state machine
  // ----------------------------------------------------------------
  cpar_pkg::cpar_state_e state_reg;
  cpar_pkg::cpar_state_e state_next;
  logic [1:0]            abort_cnt_reg;
  logic [1:0]            abort_cnt_next;
  logic                  released_reg;

  wire in_cfg_abort = (state_reg == cpar_pkg::ST_CFG_ABORT);
  wire in_rb_abort  = (state_reg == cpar_pkg::ST_RB_ABORT);
  wire abort_last   = (abort_cnt_reg == cpar_pkg::ABORT_LAST);
  wire release_now  = config_done & ~persist_en;  // [R20]

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cpar_pkg::ST_IDLE: begin
        if (released_reg) begin
          state_next = cpar_pkg::ST_RELEASED;  // [R20]
        end else if (config_clock_rise && selected) begin
          state_next = dir_read ? cpar_pkg::ST_READ : cpar_pkg::ST_WRITE;
        end
      end
      cpar_pkg::ST_WRITE: begin
        if (config_clock_rise && !selected) begin
          state_next = cpar_pkg::ST_IDLE;
        end else if (dir_flip) begin
          state_next = cpar_pkg::ST_CFG_ABORT;  // [R1]
        end
      end
      cpar_pkg::ST_READ: begin
        if (config_clock_rise && !selected) begin
          state_next = cpar_pkg::ST_IDLE;
        end else if (dir_flip) begin
          state_next = cpar_pkg::ST_RB_ABORT;  // [R1]
        end
      end
      cpar_pkg::ST_CFG_ABORT: begin
        // Fixed length; only a program pulse from the host cuts it short
        if (config_clock_rise && abort_last) begin
          state_next = cpar_pkg::ST_WAIT_DESEL;  // [R5]
        end
      end
      cpar_pkg::ST_RB_ABORT: begin
        if (config_clock_rise && !selected) begin
          state_next = cpar_pkg::ST_IDLE;  // [R7]
        end
      end
      cpar_pkg::ST_WAIT_DESEL: begin
        // Resync needs a deselect before new words count
        if (config_clock_rise && !selected) begin
          state_next = cpar_pkg::ST_IDLE;  // [R17]
        end
      end
      cpar_pkg::ST_RELEASED: begin
        state_next = cpar_pkg::ST_RELEASED;
      end
      default: begin
        state_next = cpar_pkg::ST_IDLE;
      end
    endcase
    if (prog_reset) begin
      state_next = cpar_pkg::ST_IDLE;  // [R19]
    end
  end

  always_comb begin
    abort_cnt_next = abort_cnt_reg;
    if (prog_reset || !in_cfg_abort) begin
      abort_cnt_next = cpar_pkg::ABORT_FIRST;
    end else if (config_clock_rise) begin
      abort_cnt_next = abort_cnt_reg + 2'h1;  // [R5]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= cpar_pkg::ST_IDLE;
      abort_cnt_reg <= cpar_pkg::ABORT_FIRST;
    end else begin
      state_reg     <= state_next;
      abort_cnt_reg <= abort_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Write path and alignment
  // ----------------------------------------------------------------
  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic        aligned_reg;
  logic        aligned_next;
  logic [7:0]  cfg_byte_reg;
  logic [7:0]  cfg_byte_next;
  logic        cfg_valid_reg;
  logic        cfg_valid_next;

  wire write_state = (state_reg == cpar_pkg::ST_IDLE)
                   | (state_reg == cpar_pkg::ST_WRITE);
  wire take_byte   = config_clock_rise & selected & ~dir_read & write_state
                   & ~dir_flip & ~released_reg & ~prog_reset;
  wire [31:0] shift_in   = {shift_reg[23:0], din_swap};
  wire        sync_match = (shift_in == SYNC_WORD);
  wire        align_drop = in_cfg_abort & config_clock_rise
                         & (abort_cnt_reg == cpar_pkg::ALIGN_DROP_STEP);

  always_comb begin
    shift_next     = shift_reg;
    aligned_next   = aligned_reg;
    cfg_byte_next  = cfg_byte_reg;
    cfg_valid_next = 1'b0;
    if (prog_reset) begin
      shift_next   = cpar_pkg::SHIFT_RESET;
      aligned_next = 1'b0;  // [R19]
    end else if (align_drop) begin
      // Lost in the middle of the abort, seen in the third status word
      shift_next   = cpar_pkg::SHIFT_RESET;
      aligned_next = 1'b0;  // [R15] [R16]
    end else if (take_byte && !aligned_reg) begin
      shift_next   = shift_in;
      aligned_next = sync_match;  // [R16]
    end else if (take_byte) begin
      cfg_byte_next  = din_swap;
      cfg_valid_next = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg     <= cpar_pkg::SHIFT_RESET;
      aligned_reg   <= 1'b0;
      cfg_byte_reg  <= cpar_pkg::BYTE_RESET;
      cfg_valid_reg <= 1'b0;
    end else begin
      shift_reg     <= shift_next;
      aligned_reg   <= aligned_next;
      cfg_byte_reg  <= cfg_byte_next;
      cfg_valid_reg <= cfg_valid_next;
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags: error, readback, release
  // ----------------------------------------------------------------
  logic err_n_reg;
  logic err_n_next;
  logic rb_active_reg;
  logic rb_active_next;
  logic released_next;
  logic prog_reg;

  // A set in the same cycle as a clear wins for error and readback; for release the program clear wins
  assign err_n_next = config_error_set ? 1'b0
                    : prog_reset       ? 1'b1
                    : err_n_reg;  // [R9] [R19]

  assign rb_active_next = readback_start ? 1'b1
                        : (prog_reset | readback_done
                           | (state_next == cpar_pkg::ST_RB_ABORT)) ? 1'b0
                        : rb_active_reg;  // [R11]

  assign released_next = prog_reset ? 1'b0
                       : (release_now & (state_reg == cpar_pkg::ST_IDLE))
                         | released_reg;  // [R20]

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_n_reg     <= 1'b1;
      rb_active_reg <= 1'b0;
      released_reg  <= 1'b0;
      prog_reg      <= 1'b0;
    end else begin
      err_n_reg     <= err_n_next;
      rb_active_reg <= rb_active_next;
      released_reg  <= released_next;
      prog_reg      <= prog_reset;
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  logic [7:0] status_word;

  // Abort flag low on the middle two of the four cycles
  wire abort_flag = in_cfg_abort
                  & (abort_cnt_reg >= cpar_pkg::ABORT_FLAG_START)
                  & (abort_cnt_reg <= cpar_pkg::ABORT_FLAG_END);  // [R12] [R15]

  cpar_status_word u_status (
    .err_n      (err_n_reg),      // [R9]
    .aligned    (aligned_reg),    // [R10]
    .rb_active  (rb_active_reg),  // [R11]
    .in_abort_n (~abort_flag),    // [R12]
    .word       (status_word)     // [R13]
  );

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic [7:0] dout_reg;
  logic [7:0] dout_next;
  logic       oe_reg;
  logic       oe_next;
  logic       busy_reg;
  logic       busy_next;

  // Status only while still at read; readback abort leaves pins as inputs
  wire drive_status = in_cfg_abort & selected & dir_read;  // [R2] [R4] [R8]
  wire drive_rb     = (state_reg == cpar_pkg::ST_READ) & selected
                    & dir_read & rb_active_reg;

  // Status word goes out unswapped; readback bytes are swapped
  assign dout_next = drive_status ? status_word  // [R14]
                   : drive_rb     ? rb_swap
                   : dout_reg;
  assign oe_next   = (drive_status | drive_rb) & ~prog_reset;
  assign busy_next = (in_cfg_abort | in_rb_abort) & selected;  // [R3] [R6] [R7]

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dout_reg <= cpar_pkg::BYTE_RESET;
      oe_reg   <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      dout_reg <= dout_next;
      oe_reg   <= oe_next;
      busy_reg <= busy_next;
    end
  end

  // ----------------------------------------------------------------
  // Abort indication for the core
  // ----------------------------------------------------------------
  logic abort_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      abort_reg <= 1'b0;
    end else begin
      abort_reg <= (state_next == cpar_pkg::ST_CFG_ABORT)
                 | (state_next == cpar_pkg::ST_RB_ABORT);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign data_out          = dout_reg;
  assign data_oe           = oe_reg;
  assign busy              = busy_reg;
  assign config_byte       = cfg_byte_reg;
  assign config_byte_valid = cfg_valid_reg;
  assign sync_aligned      = aligned_reg;
  assign readback_active   = rb_active_reg;
  assign config_error_n    = err_n_reg;
  assign abort_active      = abort_reg;
  assign user_io_mode      = released_reg;
  assign config_reset      = prog_reg;

endmodule

/* cpar_pkg.sv */
// Shared constants and types for the configuration port abort and resync block
package cpar_pkg;

  // ----------------------------------------------------------------
  // Port state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ,
    ST_CFG_ABORT,
    ST_RB_ABORT,
    ST_WAIT_DESEL,
    ST_RELEASED
  } cpar_state_e;

  // ----------------------------------------------------------------
  // Abort sequence timing, in configuration clock cycles
  // ----------------------------------------------------------------
  localparam logic [1:0] ABORT_FIRST      = 2'h0;
  localparam logic [1:0] ABORT_LAST       = 2'h3;
  localparam logic [1:0] ABORT_FLAG_START = 2'h1;
  localparam logic [1:0] ABORT_FLAG_END   = 2'h2;
  localparam logic [1:0] ALIGN_DROP_STEP  = 2'h1;

  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int         STAT_ERR_BIT   = 7;
  localparam int         STAT_ALIGN_BIT = 6;
  localparam int         STAT_RB_BIT    = 5;
  localparam int         STAT_ABORT_BIT = 4;
  localparam int         STAT_FILL_LSB  = 0;
  localparam int         STAT_FILL_MSB  = 3;
  localparam logic [3:0] STAT_FILL      = 4'hF;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  localparam int          BYTE_W     = 8;
  localparam int          PIN_W      = 12;
  localparam int          PIN_CONFIG_CLOCK   = 11;
  localparam int          PIN_CS_N   = 10;
  localparam int          PIN_DIR_N  = 9;
  localparam int          PIN_PROG_N = 8;
  // Idle pin levels: clock low, deselected, write, program high
  localparam logic [11:0] PIN_RESET  = 12'h500;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] SHIFT_RESET = 32'h0000_0000;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;

endpackage

/* cpar_sync.sv */
// Two-stage synchroniser for the configuration port pins
`timescale 1ns/1ps

module cpar_sync #(
  parameter int                 WIDTH     = 1,
  parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Asynchronous pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

/* cpar_status_word.sv */
// Abort status word assembly
`timescale 1ns/1ps

module cpar_status_word (
  // Status flags
  input  wire logic       err_n,
  input  wire logic       aligned,
  input  wire logic       rb_active,
  input  wire logic       in_abort_n,
  // Assembled word, not bit swapped
  output logic      [7:0] word
);

  always_comb begin
    word                                          = 8'h00;
    word[cpar_pkg::STAT_ERR_BIT]                  = err_n;
    word[cpar_pkg::STAT_ALIGN_BIT]                = aligned;
    word[cpar_pkg::STAT_RB_BIT]                   = rb_active;
    word[cpar_pkg::STAT_ABORT_BIT]                = in_abort_n;
    word[cpar_pkg::STAT_FILL_MSB:cpar_pkg::STAT_FILL_LSB] = cpar_pkg::STAT_FILL;
  end

endmodule

/* cpar_top_checker.sv */
// Assertion checker for the configuration port abort block
`timescale 1ns/1ps

module cpar_top_checker (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // Core inputs
  input wire logic       config_error_set,
  input wire logic       readback_start,
  input wire logic       config_done,
  input wire logic       persist_en,
  // Observed outputs
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       busy,
  input wire logic       config_byte_valid,
  input wire logic       sync_aligned,
  input wire logic       readback_active,
  input wire logic       config_error_n,
  input wire logic       abort_active,
  input wire logic       user_io_mode,
  input wire logic       config_reset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  wire status_on = data_oe && abort_active;

  // ----------------------------------------------------------------
  // Abort sequence steps
  // ----------------------------------------------------------------
  // Bench link clock is 8 mclk, so four link cycles span about 32 mclk
  sequence s_abort_enter; $rose(status_on); endsequence
  sequence s_abort_hold;  abort_active [*8]; endsequence
  sequence s_abort_exit;  ##[20:40] !abort_active; endsequence

  property p_abort_len; s_abort_enter |-> s_abort_hold ##0 s_abort_exit; endproperty
  property p_fill;      status_on |-> data_out[3:0] == 4'hF; endproperty
  property p_err_bit;
    status_on && $stable(config_error_n) |-> data_out[7] == config_error_n;
  endproperty
  // Busy trails the state by one mclk
  property p_busy;      busy |-> abort_active || $past(abort_active); endproperty
  property p_prog;
    config_reset |=> !sync_aligned && !abort_active && !busy && !readback_active;
  endproperty
  property p_release;   $rose(user_io_mode) |-> $past(config_done) && !$past(persist_en); endproperty
  property p_quiet;     user_io_mode |-> !data_oe; endproperty
  property p_valid;     config_byte_valid |-> sync_aligned; endproperty
  property p_rb_start;  $rose(readback_active) |-> $past(readback_start); endproperty
  property p_err_set;   $fell(config_error_n) |-> $past(config_error_set); endproperty

  a_abort_len: assert property (p_abort_len) else $error("abort length wrong");
  a_fill: assert property (p_fill) else $error("status low nibble not ones");
  a_err_bit: assert property (p_err_bit) else $error("status error bit wrong");
  a_busy: assert property (p_busy) else $error("busy outside abort");
  a_prog: assert property (p_prog) else $error("program did not reset");
  a_release: assert property (p_release) else $error("release without cause");
  a_quiet: assert property (p_quiet) else $error("released port drives data");
  a_valid: assert property (p_valid) else $error("byte delivered unaligned");
  a_rb_start: assert property (p_rb_start) else $error("readback flag without start");
  a_err_set: assert property (p_err_set) else $error("error flag without cause");
endmodule

bind cpar_top cpar_top_checker u_chk (.mclk, .rst_n, .config_error_set, .readback_start,
  .config_done, .persist_en, .data_out, .data_oe, .busy, .config_byte_valid, .sync_aligned,
  .readback_active, .config_error_n, .abort_active, .user_io_mode, .config_reset);

/* cpar_host_model.sv */
// Host controller model driving the configuration port pins
`timescale 1ns/1ps

module cpar_host_model (
  // Clock
  input  wire logic       mclk,
  // Pins towards the device
  output logic            config_clock,
  output logic            chip_sel_n,
  output logic            read_write_dir_n,
  output logic            program_n,
  output logic      [7:0] data_in,
  // Device drive of the data pins
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  logic [7:0] host_byte;
  logic       host_drv;

  initial begin
    config_clock     = 1'b0;
    chip_sel_n       = 1'b1;
    read_write_dir_n = 1'b0;
    program_n        = 1'b1;
    data_in          = 8'h00;
    host_byte        = 8'h00;
    host_drv         = 1'b0;
  end

  // Released lines toggle so a stale byte never looks valid
  always @(posedge mclk) begin
    if (data_oe)
      data_in <= data_out;
    else if (host_drv)
      data_in <= host_byte;
    else
      data_in <= ~data_in;
  end

  // ----------------------------------------------------------------
  // One link clock period of 8 mclk; clock idles low between calls
  // ----------------------------------------------------------------
  task automatic tick(input logic dir_n, input logic [7:0] d, input logic cs_n);
    chip_sel_n       <= cs_n;
    read_write_dir_n <= dir_n;
    host_drv         <= !dir_n && !cs_n;
    host_byte        <= d;
    @(posedge mclk);
    config_clock <= 1'b1;
    repeat (4) @(posedge mclk);
    config_clock <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic pulse_program;
    program_n <= 1'b0;
    repeat (4) @(posedge mclk);
    program_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
endmodule

/* cpar_top_tb.sv */
// Self-checking bench for the configuration port abort block
`timescale 1ns/1ps

module cpar_top_tb;
  localparam logic [31:0] SYNC = 32'hA5C3_5AC3;

  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       config_error_set = 1'b0;
  logic       readback_start = 1'b0;
  logic       readback_done = 1'b0;
  logic [7:0] readback_data = 8'h00;
  logic       config_done = 1'b0;
  logic       persist_en = 1'b0;
  wire        config_clock, chip_sel_n, read_write_dir_n, program_n;
  wire  [7:0] data_in, data_out, config_byte;
  wire        data_oe, busy, config_byte_valid, sync_aligned, readback_active;
  wire        config_error_n, abort_active, user_io_mode, config_reset;
  int         failures = 0;
  int         comparisons = 0;
  int         valid_cnt = 0;

  cpar_top #(.SYNC_WORD(SYNC)) u_dut (.mclk, .rst_n, .config_clock, .chip_sel_n,
    .read_write_dir_n, .program_n, .data_in, .data_out, .data_oe, .busy,
    .config_error_set, .readback_start, .readback_done, .readback_data, .config_done,
    .persist_en, .config_byte, .config_byte_valid, .sync_aligned, .readback_active,
    .config_error_n, .abort_active, .user_io_mode, .config_reset);

  cpar_host_model u_host (.mclk, .config_clock, .chip_sel_n, .read_write_dir_n,
    .program_n, .data_in, .data_out, .data_oe);

  always #5 mclk = ~mclk;

  always @(posedge mclk) begin
    if (config_byte_valid === 1'b1)
      valid_cnt++;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rev(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      rev[i] = b[7-i];
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_sync;
    int n;
    n = valid_cnt;
    u_host.tick(1'b0, 8'hFF, 1'b0);
    for (int i = 3; i >= 0; i--)
      u_host.tick(1'b0, rev(SYNC[i*8 +: 8]), 1'b0);
    chk(8'(sync_aligned), 8'h01);
    chk(8'(valid_cnt - n), 8'h00);
  endtask

  task automatic t_byte;
    int n;
    n = valid_cnt;
    u_host.tick(1'b0, 8'h12, 1'b0);
    chk(8'(valid_cnt - n), 8'h01);
    chk(config_byte, 8'h48);
  endtask

  task automatic t_cfg_abort(input logic err);
    logic [7:0] exp [4] = '{8'hDF, 8'hCF, 8'h8F, 8'h9F};
    for (int i = 0; i < 4; i++) begin
      u_host.tick(1'b1, 8'h00, 1'b0);
      chk({data_oe, busy, 6'h00}, 8'hC0);
      chk(data_out, exp[i] & {~err, 7'h7F});
    end
    u_host.tick(1'b1, 8'h00, 1'b0);
    chk({data_oe, busy, sync_aligned, 5'h00}, 8'h00);
    u_host.tick(1'b1, 8'h00, 1'b1);
    chk(8'(abort_active), 8'h00);
    t_sync();
  endtask

  task automatic t_rb_abort;
    @(posedge mclk);
    readback_start <= 1'b1;
    readback_data  <= 8'h01;
    @(posedge mclk);
    readback_start <= 1'b0;
    u_host.tick(1'b0, 8'h00, 1'b1);
    u_host.tick(1'b1, 8'h00, 1'b0);
    chk({data_oe, busy, readback_active, 5'h00}, 8'hA0);
    chk(data_out, 8'h80);
    for (int i = 0; i < 3; i++) begin
      u_host.tick(1'b0, 8'h00, 1'b0);
      chk({data_oe, busy, readback_active, abort_active, 4'h0}, 8'h50);
    end
    u_host.tick(1'b0, 8'h00, 1'b1);
    chk({busy, abort_active, 6'h00}, 8'h00);
    readback_start <= 1'b1;
    @(posedge mclk);
    readback_start <= 1'b0;
    readback_done  <= 1'b1;
    @(posedge mclk);
    readback_done <= 1'b0;
    @(posedge mclk);
    chk(8'(readback_active), 8'h00);
  endtask

  task automatic t_error;
    @(posedge mclk);
    config_error_set <= 1'b1;
    @(posedge mclk);
    config_error_set <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(8'(config_error_n), 8'h00);
  endtask

  // Program pulse in the last abort cycle
  task automatic t_program;
    for (int i = 0; i < 3; i++)
      u_host.tick(1'b1, 8'h00, 1'b0);
    // Direction back to write: status must leave the pins, busy stays
    u_host.tick(1'b0, 8'h5A, 1'b0);
    chk({data_oe, busy, 6'h00}, 8'h40);
    u_host.pulse_program();
    chk({busy, abort_active, sync_aligned, config_error_n, 4'h0}, 8'h10);
  endtask

  task automatic t_release;
    int k;
    u_host.tick(1'b0, 8'h00, 1'b1);
    persist_en  <= 1'b1;
    config_done <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(8'(user_io_mode), 8'h00);
    persist_en <= 1'b0;
    k = 0;
    while (user_io_mode !== 1'b1 && k < 10) begin
      @(posedge mclk);
      k++;
    end
    chk(8'(user_io_mode), 8'h01);
    config_done <= 1'b0;
    u_host.pulse_program();
    chk(8'(user_io_mode), 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_sync();
    t_byte();
    t_cfg_abort(1'b0);
    t_rb_abort();
    t_error();
    t_byte();
    t_cfg_abort(1'b1);
    t_program();
    t_release();
    final_report();
  end

  initial begin
    #500000;
    failures++;
    final_report();
  end
endmodule
